// >>> src/metering_config_pkg.sv
// constants and types for the metering configuration register block
package metering_config_pkg;

    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 32;
    localparam int SAMPLE_W    = 24;
    localparam int PHASE_COUNT = 3;

    localparam logic [ADDR_W-1:0] CONFIG_ADDR = 16'he618;

    // field positions in the configuration word
    localparam int INTEGRATOR_BIT  = 0;
    localparam int SWAP_BIT        = 3;
    localparam int VOLTAGE_GND_BIT = 4;
    localparam int CURRENT_GND_BIT = 5;
    localparam int FAST_PORT_BIT   = 6;
    localparam int SOFT_RESET_BIT  = 7;
    localparam int FIRST_SEL_LSB   = 8;
    localparam int SECOND_SEL_LSB  = 10;
    localparam int THIRD_SEL_LSB   = 12;

    localparam logic [15:0] CONFIG_RESET   = 16'h0000;
    localparam logic [15:0] WRITABLE_MASK  = 16'h3ff9;
    localparam logic [15:0] READ_PAD       = 16'h0000;
    localparam logic [2:0]  PHASE_MODULO   = 3'h3;

    localparam logic [1:0] PHASE_A = 2'h0;
    localparam logic [1:0] PHASE_B = 2'h1;
    localparam logic [1:0] PHASE_C = 2'h2;

    // voltage choice relative to the phase's own voltage
    typedef enum logic [1:0] {
        SEL_OWN      = 2'b00,
        SEL_NEXT     = 2'b01,
        SEL_PREV     = 2'b10,
        SEL_RESERVED = 2'b11
    } phase_sel_type;

    typedef enum logic {
        BUS_IDLE    = 1'b0,
        BUS_RESPOND = 1'b1
    } bus_state_type;

    typedef logic [SAMPLE_W-1:0] sample_type;
    typedef sample_type [PHASE_COUNT-1:0] phase_samples_type;

    typedef struct packed {
        logic [1:0]    reserved_high;
        phase_sel_type voltage_for_third_phase;
        phase_sel_type voltage_for_second_phase;
        phase_sel_type voltage_for_first_phase;
        logic          soft_reset_request;
        logic          fast_capture_port_enable;
        logic          current_adc_grounded;
        logic          voltage_adc_grounded;
        logic          channel_swap;
        logic [1:0]    reserved_low;
        logic          integrator_enable;
    } config_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } apb_rsp_type;

    typedef struct packed {
        bus_state_type     bus_state;
        apb_rsp_type       rsp;
        config_type        cfg;
        logic              soft_reset_pulse;
        logic              shared_pin;
        phase_samples_type voltage_result;
        phase_samples_type current_result;
        phase_samples_type paired_voltage;
    } state_type;

    // phase whose voltage feeds the power path of phase own
    function automatic logic [1:0] phase_index(input logic [1:0] own,
                                               input phase_sel_type code);
        logic [2:0] sum;
        logic [1:0] step;
        step = (code == SEL_RESERVED) ? SEL_OWN : code;
        sum  = {1'b0, own} + {1'b0, step};
        phase_index = (sum >= PHASE_MODULO) ? 2'(sum - PHASE_MODULO) : sum[1:0];
    endfunction : phase_index

endpackage : metering_config_pkg

// >>> src/metering_config_register.sv
// apb configuration register with channel routing and phase pairing
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

// Overview of operation
// - bit 0 set enables the integrator on all phase and neutral currents, clear disables it.
// - bits 2:1 and 15:14 are reserved, are not stored and steer nothing.
// - bit 3 set exchanges voltage channel outputs with current channel outputs.
// - bit 4 set makes the voltage channel outputs read as grounded inputs.
// - bit 5 set makes the current channel outputs read as grounded inputs.
// - bit 6 set enables the fast capture port and puts its clock on the shared pin.
// - writing 1 to bit 7 starts a software reset.
// - field 9:8 picks phase a, b or c voltage for the first phase power path, 11 as 00.
// - field 11:10 picks phase b, c or a voltage for the second phase, 11 as 00.
// - field 13:12 picks phase c, a or b voltage for the third phase, 11 as 00.
module metering_config_register (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire metering_config_pkg::apb_req_type       apb_req,
    output      metering_config_pkg::apb_rsp_type       apb_rsp,
    input  wire metering_config_pkg::phase_samples_type voltage_sample,
    input  wire metering_config_pkg::phase_samples_type current_sample,
    input  wire logic                                  fast_capture_clock,
    input  wire logic                                  third_pulse_output,
    output      metering_config_pkg::config_type        datapath_control,
    output      logic                                  soft_reset_pulse,
    output      logic                                  shared_pin,
    output      metering_config_pkg::phase_samples_type voltage_result,
    output      metering_config_pkg::phase_samples_type current_result,
    output      metering_config_pkg::phase_samples_type paired_voltage
);
    import metering_config_pkg::*;

    localparam state_type STATE_RESET = '0;

    state_type state;
    state_type next_state;

    logic access;
    logic addr_hit;
    logic commit;

    phase_samples_type grounded_voltage;
    phase_samples_type grounded_current;
    phase_sel_type     pair_code [PHASE_COUNT];

    assign access   = apb_req.psel && apb_req.penable;
    assign addr_hit = (apb_req.paddr == CONFIG_ADDR);
    assign commit   = access && (state.bus_state == BUS_RESPOND);

    always_comb begin
        next_state = state;
        pair_code[PHASE_A] = state.cfg.voltage_for_first_phase;
        pair_code[PHASE_B] = state.cfg.voltage_for_second_phase;
        pair_code[PHASE_C] = state.cfg.voltage_for_third_phase;

        // bus: one wait cycle, answer registered
        case (state.bus_state)
            BUS_IDLE: begin
                next_state.rsp.pready  = 1'b0;
                next_state.rsp.pslverr = 1'b0;
                if (access) begin
                    next_state.bus_state   = BUS_RESPOND;
                    next_state.rsp.pready  = 1'b1;
                    next_state.rsp.pslverr = !addr_hit;
                    next_state.rsp.prdata  = addr_hit ? {READ_PAD, state.cfg} : '0;
                end
            end
            BUS_RESPOND: begin
                next_state.bus_state   = BUS_IDLE;
                next_state.rsp.pready  = 1'b0;
                next_state.rsp.pslverr = 1'b0;
            end
            default: begin
                next_state.bus_state  = BUS_IDLE;
                next_state.rsp.pready = 1'b0;
            end
        endcase

        // write takes effect at the edge that sees pready high
        if (commit && apb_req.pwrite && addr_hit) begin
            next_state.cfg = config_type'(apb_req.pwdata[15:0] & WRITABLE_MASK);
        end

        // software reset: request seen, pulse out, all fields back to zero
        next_state.soft_reset_pulse = state.cfg.soft_reset_request;
        if (state.cfg.soft_reset_request) begin
            next_state.cfg = config_type'(CONFIG_RESET);
        end

        // grounding acts on the adc outputs, the exchange follows it
        grounded_voltage = state.cfg.voltage_adc_grounded ? '0 : voltage_sample;
        grounded_current = state.cfg.current_adc_grounded ? '0 : current_sample;
        if (state.cfg.channel_swap) begin
            next_state.voltage_result = grounded_current;
            next_state.current_result = grounded_voltage;
        end else begin
            next_state.voltage_result = grounded_voltage;
            next_state.current_result = grounded_current;
        end

        // power path pairing from the voltage channel
        for (int p = 0; p < PHASE_COUNT; p++) begin
            next_state.paired_voltage[p] =
                state.voltage_result[phase_index(2'(p), pair_code[p])];
        end

        // shared pin function
        next_state.shared_pin = state.cfg.fast_capture_port_enable ?
                                fast_capture_clock : third_pulse_output;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign apb_rsp          = state.rsp;
    assign datapath_control = state.cfg;
    assign soft_reset_pulse = state.soft_reset_pulse;
    assign shared_pin       = state.shared_pin;
    assign voltage_result   = state.voltage_result;
    assign current_result   = state.current_result;
    assign paired_voltage   = state.paired_voltage;

    // checking helpers
    logic write_hit;

    assign write_hit = commit && apb_req.pwrite && addr_hit;

    default clocking chk_clk @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_integrator_write: assert property (
        write_hit && !state.cfg.soft_reset_request
        |=> datapath_control.integrator_enable == $past(apb_req.pwdata[INTEGRATOR_BIT]))
        else $error("integrator enable does not follow written bit");

    chk_reserved_zero: assert property (
        datapath_control.reserved_low == '0 && datapath_control.reserved_high == '0 &&
        apb_rsp.prdata[15:14] == '0)
        else $error("reserved configuration bits not zero");

    chk_config_hold: assert property (
        !write_hit && !state.cfg.soft_reset_request |=> $stable(datapath_control))
        else $error("configuration changed without a write");

    chk_write_value: assert property (
        write_hit && !state.cfg.soft_reset_request
        |=> datapath_control == config_type'($past(apb_req.pwdata[15:0]) & WRITABLE_MASK))
        else $error("written value not stored with reserved bits dropped");

    chk_reserved_read: assert property (
        apb_rsp.pready |-> apb_rsp.prdata[2:1] == '0 && apb_rsp.prdata[31:16] == '0)
        else $error("reserved or unused read bits not zero");

    chk_unmapped_ignored: assert property (
        commit && !addr_hit && !state.cfg.soft_reset_request |=> $stable(datapath_control))
        else $error("access to another address changed the register");

    chk_unmapped_error: assert property (
        access && !apb_rsp.pready && !addr_hit
        |=> apb_rsp.pslverr && apb_rsp.prdata == '0)
        else $error("unmapped access not answered with an error");

    chk_swap_route: assert property (
        $past(state.cfg.channel_swap && !state.cfg.current_adc_grounded)
        |-> voltage_result == $past(current_sample))
        else $error("voltage result does not carry current when swapped");

    chk_swap_current: assert property (
        $past(state.cfg.channel_swap && !state.cfg.voltage_adc_grounded)
        |-> current_result == $past(voltage_sample))
        else $error("current result does not carry voltage when swapped");

    chk_plain_voltage: assert property (
        $past(presetn && !state.cfg.channel_swap && !state.cfg.voltage_adc_grounded)
        |-> voltage_result == $past(voltage_sample))
        else $error("voltage result does not carry voltage");

    chk_plain_current: assert property (
        $past(presetn && !state.cfg.channel_swap && !state.cfg.current_adc_grounded)
        |-> current_result == $past(current_sample))
        else $error("current result does not carry current");

    chk_voltage_ground: assert property (
        $past(state.cfg.voltage_adc_grounded && !state.cfg.channel_swap)
        |-> voltage_result == '0)
        else $error("voltage channel not grounded");

    chk_voltage_ground_swap: assert property (
        $past(state.cfg.voltage_adc_grounded && state.cfg.channel_swap)
        |-> current_result == '0)
        else $error("grounded voltage channel not zero after the exchange");

    chk_current_ground: assert property (
        $past(state.cfg.current_adc_grounded) && !$past(state.cfg.channel_swap)
        |-> current_result == '0)
        else $error("current channel not grounded");

    chk_current_ground_swap: assert property (
        $past(state.cfg.current_adc_grounded && state.cfg.channel_swap)
        |-> voltage_result == '0)
        else $error("grounded current channel not zero after the exchange");

    chk_shared_pin: assert property (
        $past(presetn) |->
        shared_pin == ($past(state.cfg.fast_capture_port_enable) ?
                       $past(fast_capture_clock) : $past(third_pulse_output)))
        else $error("shared pin carries wrong function");

    chk_clock_on_pin: assert property (
        $past(presetn && state.cfg.fast_capture_port_enable)
        |-> shared_pin == $past(fast_capture_clock))
        else $error("shared pin does not carry the fast capture clock");

    chk_pulse_on_pin: assert property (
        $past(presetn && !state.cfg.fast_capture_port_enable)
        |-> shared_pin == $past(third_pulse_output))
        else $error("shared pin does not carry the third pulse output");

    chk_soft_reset_start: assert property (
        write_hit && apb_req.pwdata[SOFT_RESET_BIT] && !state.cfg.soft_reset_request
        |=> datapath_control.soft_reset_request ##1 soft_reset_pulse)
        else $error("software reset not started");

    chk_soft_reset_single: assert property (
        soft_reset_pulse |=> !soft_reset_pulse)
        else $error("software reset pulse longer than one cycle");

    chk_pulse_source: assert property (
        soft_reset_pulse |-> $past(datapath_control.soft_reset_request))
        else $error("software reset pulse without a request");

    chk_first_own: assert property (
        $past(state.cfg.voltage_for_first_phase) == SEL_OWN
        |-> paired_voltage[PHASE_A] == $past(state.voltage_result[PHASE_A]))
        else $error("first phase own code paired with wrong voltage");

    chk_first_pairing: assert property (
        $past(state.cfg.voltage_for_first_phase) == SEL_NEXT
        |-> paired_voltage[PHASE_A] == $past(state.voltage_result[PHASE_B]))
        else $error("first phase paired with wrong voltage");

    chk_first_prev: assert property (
        $past(state.cfg.voltage_for_first_phase) == SEL_PREV
        |-> paired_voltage[PHASE_A] == $past(state.voltage_result[PHASE_C]))
        else $error("first phase code 10 paired with wrong voltage");

    chk_first_reserved: assert property (
        $past(state.cfg.voltage_for_first_phase) == SEL_RESERVED
        |-> paired_voltage[PHASE_A] == $past(state.voltage_result[PHASE_A]))
        else $error("first phase reserved code not as own voltage");

    chk_second_own: assert property (
        $past(state.cfg.voltage_for_second_phase) == SEL_OWN
        |-> paired_voltage[PHASE_B] == $past(state.voltage_result[PHASE_B]))
        else $error("second phase own code paired with wrong voltage");

    chk_second_next: assert property (
        $past(state.cfg.voltage_for_second_phase) == SEL_NEXT
        |-> paired_voltage[PHASE_B] == $past(state.voltage_result[PHASE_C]))
        else $error("second phase code 01 paired with wrong voltage");

    chk_second_pairing: assert property (
        $past(state.cfg.voltage_for_second_phase) == SEL_PREV
        |-> paired_voltage[PHASE_B] == $past(state.voltage_result[PHASE_A]))
        else $error("second phase paired with wrong voltage");

    chk_second_reserved: assert property (
        $past(state.cfg.voltage_for_second_phase) == SEL_RESERVED
        |-> paired_voltage[PHASE_B] == $past(state.voltage_result[PHASE_B]))
        else $error("second phase reserved code not as own voltage");

    chk_third_own: assert property (
        $past(state.cfg.voltage_for_third_phase) == SEL_OWN
        |-> paired_voltage[PHASE_C] == $past(state.voltage_result[PHASE_C]))
        else $error("third phase own code paired with wrong voltage");

    chk_third_next: assert property (
        $past(state.cfg.voltage_for_third_phase) == SEL_NEXT
        |-> paired_voltage[PHASE_C] == $past(state.voltage_result[PHASE_A]))
        else $error("third phase code 01 paired with wrong voltage");

    chk_third_prev: assert property (
        $past(state.cfg.voltage_for_third_phase) == SEL_PREV
        |-> paired_voltage[PHASE_C] == $past(state.voltage_result[PHASE_B]))
        else $error("third phase code 10 paired with wrong voltage");

    chk_third_reserved: assert property (
        $past(state.cfg.voltage_for_third_phase) == SEL_RESERVED
        |-> paired_voltage[PHASE_C] == $past(state.voltage_result[PHASE_C]))
        else $error("third phase reserved code not as own voltage");

    chk_soft_reset_clear: assert property (
        datapath_control.soft_reset_request
        |=> soft_reset_pulse && datapath_control == config_type'(CONFIG_RESET))
        else $error("software reset did not clear the register");

    chk_apb_answer: assert property (
        access && !apb_rsp.pready |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("bus answer not given in one wait cycle");

    chk_apb_single: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("bus answer longer than one cycle");

    chk_read_value: assert property (
        access && !apb_rsp.pready && addr_hit && !apb_req.pwrite
        |=> apb_rsp.prdata == {READ_PAD, $past(datapath_control)})
        else $error("read data does not show the register");

    cov_config_write: cover property (write_hit);
    cov_config_read: cover property (commit && !apb_req.pwrite && addr_hit);
    cov_soft_reset: cover property (soft_reset_pulse);
    cov_swap_active: cover property (datapath_control.channel_swap ##1 voltage_result != '0);
    cov_pair_reserved: cover property (datapath_control.voltage_for_third_phase == SEL_RESERVED);

endmodule : metering_config_register

// >>> tb/tb.sv
// self-checking bench for the metering configuration register
`timescale 1ns/1ps
module tb;
    import metering_config_pkg::*;

    logic              pclk;
    logic              presetn;
    apb_req_type       apb_req;
    apb_rsp_type       apb_rsp;
    phase_samples_type voltage_sample;
    phase_samples_type current_sample;
    logic              fast_capture_clock;
    logic              third_pulse_output;
    config_type        datapath_control;
    logic              soft_reset_pulse;
    logic              shared_pin;
    phase_samples_type voltage_result;
    phase_samples_type current_result;
    phase_samples_type paired_voltage;
    int                n_errors;
    int                comparisons;
    int                cycles;
    logic [31:0]       rd;
    logic [31:0]       d;
    logic [31:0]       ex;
    logic              err;
    config_type        c;

    metering_config_register i_dut (
        .pclk               (pclk),
        .presetn            (presetn),
        .apb_req            (apb_req),
        .apb_rsp            (apb_rsp),
        .voltage_sample     (voltage_sample),
        .current_sample     (current_sample),
        .fast_capture_clock (fast_capture_clock),
        .third_pulse_output (third_pulse_output),
        .datapath_control   (datapath_control),
        .soft_reset_pulse   (soft_reset_pulse),
        .shared_pin         (shared_pin),
        .voltage_result     (voltage_result),
        .current_result     (current_result),
        .paired_voltage     (paired_voltage)
    );

    always #20 pclk = ~pclk;

    task automatic stop_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            $display("[FAIL] %0t timeout", $time);
            n_errors++;
            stop_test();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check_word

    task automatic check_set(input phase_samples_type got, input phase_samples_type exp,
                             input string m);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check_set

    // one apb transfer, setup at the next rising edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rdata, output logic serr);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        serr  = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    function automatic phase_samples_type exp_volt(config_type k, phase_samples_type v,
                                                   phase_samples_type i, logic cur);
        phase_samples_type vg;
        phase_samples_type cg;
        vg = k.voltage_adc_grounded ? '0 : v;
        cg = k.current_adc_grounded ? '0 : i;
        if (cur) return k.channel_swap ? vg : cg;
        return k.channel_swap ? cg : vg;
    endfunction : exp_volt

    function automatic phase_samples_type exp_pair(config_type k, phase_samples_type vr);
        logic [1:0] code [3];
        int         s;
        code[0] = k.voltage_for_first_phase;
        code[1] = k.voltage_for_second_phase;
        code[2] = k.voltage_for_third_phase;
        for (int p = 0; p < 3; p++) begin
            s = (code[p] == 2'h3) ? 0 : int'(code[p]);
            exp_pair[p] = vr[(p + s) % 3];
        end
    endfunction : exp_pair

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        voltage_sample = '0;
        current_sample = '0;
        fast_capture_clock = 1'b0;
        third_pulse_output = 1'b0;
        void'($urandom(3));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CONFIG_ADDR, 32'h0, rd, err);
        check_word(rd, 32'h0, "reset read");
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            d[7] = 1'b0;
            d[9:8] = 2'(i);
            d[11:10] = 2'(i >> 2);
            d[13:12] = 2'(i) ^ 2'(i >> 2);
            apb(1'b1, CONFIG_ADDR, d, rd, err);
            ex = d & 32'h0000_3f79;
            apb(1'b0, CONFIG_ADDR, 32'h0, rd, err);
            check_word(rd, ex, "read back");
            voltage_sample <= phase_samples_type'({$urandom, $urandom, $urandom});
            current_sample <= phase_samples_type'({$urandom, $urandom, $urandom});
            fast_capture_clock <= 1'($urandom);
            third_pulse_output <= 1'($urandom);
            repeat (3) @(posedge pclk);
            #1;
            c = config_type'(ex[15:0]);
            check_word(32'(datapath_control), ex, "control");
            check_set(voltage_result, exp_volt(c, voltage_sample, current_sample, 1'b0),
                      "voltage");
            check_set(current_result, exp_volt(c, voltage_sample, current_sample, 1'b1),
                      "current");
            check_set(paired_voltage, exp_pair(c, exp_volt(c, voltage_sample,
                      current_sample, 1'b0)), "paired");
            check_word(32'(shared_pin), 32'(c.fast_capture_port_enable ? fast_capture_clock
                       : third_pulse_output), "shared pin");
        end
        apb(1'b1, CONFIG_ADDR + 16'h4, 32'hffff_ffff, rd, err);
        check_word(32'(err), 32'h1, "unmapped write error");
        apb(1'b0, CONFIG_ADDR + 16'h4, 32'h0, rd, err);
        check_word(rd, 32'h0, "unmapped read data");
        check_word(32'(datapath_control), ex, "unmapped write ignored");
        apb(1'b1, CONFIG_ADDR, $urandom | 32'h0000_0080, rd, err);
        #1;
        check_word(32'(datapath_control.soft_reset_request), 32'h1, "request");
        @(posedge pclk);
        #1;
        check_word(32'(soft_reset_pulse), 32'h1, "reset pulse");
        check_word(32'(datapath_control), 32'h0, "fields cleared");
        @(posedge pclk);
        #1;
        check_word(32'(soft_reset_pulse), 32'h0, "pulse ends");
        apb(1'b0, CONFIG_ADDR, 32'h0, rd, err);
        check_word(rd, 32'h0, "read after reset");
        apb(1'b1, CONFIG_ADDR, 32'h0000_1f59, rd, err);
        #1;
        check_word(32'(datapath_control), 32'h0000_1f59, "write before reset");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check_word(32'(datapath_control), 32'h0, "cleared by bus reset");
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CONFIG_ADDR, 32'h0, rd, err);
        check_word(rd, 32'h0, "read after bus reset");
        stop_test();
    end
endmodule : tb
